// [src/smd_decode.sv]
// smd_decode: stack/miscellaneous opcode decode and processor status word
// condition-flag update.
// assumes: one core clock; every input is driven by core logic on that clock.
`timescale 1ns/1ns
`include "smd_defs.svh"

module smd_decode
    import smd_pkg::*;
#(
    parameter int PSW_W = 32
) (
    input  wire logic              i_core_clk,
    input  wire logic              i_rst,
    // opcode decode request
    input  wire logic              i_op_valid,
    input  wire logic [7:0]        i_opcode,
    output logic                   o_dec_valid,
    output smd_class_e             o_dec_class,
    output logic [2:0]             o_len_min,
    output logic [2:0]             o_len_max,
    output logic [2:0]             o_pc_advance,
    output logic                   o_flags_keep,
    output logic                   o_trap_req,
    output logic                   o_icache_inval,
    // flag update request
    input  wire logic              i_flag_valid,
    input  wire logic [3:0]        i_flag_case,
    input  wire logic [31:0]       i_dst,
    input  wire logic [31:0]       i_src,
    input  wire smd_width_e        i_width,
    input  wire logic              i_signed,
    input  wire logic              i_carry,
    input  wire logic              i_int_ovf,
    input  wire logic              i_expanded,
    input  wire logic              i_truncated,
    input  wire logic              i_type_changed,
    input  wire logic [63:0]       i_abs_result,
    input  wire logic              i_psw_is_src,
    input  wire logic              i_psw_is_dst,
    input  wire logic [PSW_W-1:0]  i_new_psw,
    input  wire logic              i_cop_accept,
    input  wire logic [31:0]       i_cop_word,
    output logic [PSW_W-1:0]       o_psw,
    output logic                   o_flag_n,
    output logic                   o_flag_z,
    output logic                   o_flag_v,
    output logic                   o_flag_c
);

    // ============================================================
    // decode stage
    logic        dec_valid_r,  dec_valid_nxt;
    smd_class_e  dec_class_r,  dec_class_nxt;
    logic [2:0]  len_min_r,    len_min_nxt;
    logic [2:0]  len_max_r,    len_max_nxt;
    logic [2:0]  pc_adv_r,     pc_adv_nxt;
    logic        keep_r,       keep_nxt;
    logic        trap_r,       trap_nxt;
    logic        inval_r,      inval_nxt;

    // next decode values from the opcode
    always_comb begin
        dec_valid_nxt = 1'b0;
        dec_class_nxt = SMD_CLS_NONE;
        len_min_nxt   = `SMD_LEN_NONE;
        len_max_nxt   = `SMD_LEN_NONE;
        pc_adv_nxt    = `SMD_LEN_NONE;
        keep_nxt      = 1'b0;
        trap_nxt      = 1'b0;
        inval_nxt     = 1'b0;
        if (i_op_valid) begin
            dec_valid_nxt = 1'b1;
            unique case (i_opcode)
                `SMD_OP_PUSH_EFF_ADDR: begin
                    dec_class_nxt = SMD_CLS_PUSH_EFF;
                    len_min_nxt   = `SMD_LEN_STACK_MIN;
                    len_max_nxt   = `SMD_LEN_STACK_MAX;
                end
                `SMD_OP_PUSH_WORD: begin
                    dec_class_nxt = SMD_CLS_PUSH_WORD;
                    len_min_nxt   = `SMD_LEN_STACK_MIN;
                    len_max_nxt   = `SMD_LEN_STACK_MAX;
                end
                `SMD_OP_POP_WORD: begin
                    dec_class_nxt = SMD_CLS_POP_WORD;
                    len_min_nxt   = `SMD_LEN_STACK_MIN;
                    len_max_nxt   = `SMD_LEN_STACK_MAX;
                end
                `SMD_OP_IDLE_ONE: begin
                    dec_class_nxt = SMD_CLS_IDLE_ONE;
                    len_min_nxt   = `SMD_LEN_ONE;
                    len_max_nxt   = `SMD_LEN_ONE;
                    pc_adv_nxt    = `SMD_LEN_ONE;
                    keep_nxt      = 1'b1;
                end
                `SMD_OP_IDLE_TWO: begin
                    dec_class_nxt = SMD_CLS_IDLE_TWO;
                    len_min_nxt   = `SMD_LEN_TWO;
                    len_max_nxt   = `SMD_LEN_TWO;
                    pc_adv_nxt    = `SMD_LEN_TWO;
                    keep_nxt      = 1'b1;
                end
                `SMD_OP_IDLE_THREE: begin
                    dec_class_nxt = SMD_CLS_IDLE_THREE;
                    len_min_nxt   = `SMD_LEN_THREE;
                    len_max_nxt   = `SMD_LEN_THREE;
                    pc_adv_nxt    = `SMD_LEN_THREE;
                    keep_nxt      = 1'b1;
                end
                `SMD_OP_BREAKPOINT: begin
                    dec_class_nxt = SMD_CLS_BREAKPOINT;
                    len_min_nxt   = `SMD_LEN_ONE;
                    len_max_nxt   = `SMD_LEN_ONE;
                    keep_nxt      = 1'b1;
                    trap_nxt      = 1'b1;
                end
                `SMD_OP_ICACHE_INVAL: begin
                    dec_class_nxt = SMD_CLS_ICACHE_INV;
                    len_min_nxt   = `SMD_LEN_ONE;
                    len_max_nxt   = `SMD_LEN_ONE;
                    keep_nxt      = 1'b1;
                    inval_nxt     = 1'b1;
                end
                `SMD_OP_EXTENSION: begin
                    dec_class_nxt = SMD_CLS_EXTENSION;
                    len_min_nxt   = `SMD_LEN_ONE;
                    len_max_nxt   = `SMD_LEN_TWO;
                    keep_nxt      = 1'b1;
                end
                default: begin
                    dec_valid_nxt = 1'b0;                               // not in this group
                end
            endcase
        end
    end

    // decode registers
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            dec_valid_r <= 1'b0;
            dec_class_r <= SMD_CLS_NONE;
            len_min_r   <= `SMD_LEN_NONE;
            len_max_r   <= `SMD_LEN_NONE;
            pc_adv_r    <= `SMD_LEN_NONE;
            keep_r      <= 1'b0;
            trap_r      <= 1'b0;
            inval_r     <= 1'b0;
        end else begin
            dec_valid_r <= dec_valid_nxt;
            dec_class_r <= dec_class_nxt;
            len_min_r   <= len_min_nxt;
            len_max_r   <= len_max_nxt;
            pc_adv_r    <= pc_adv_nxt;
            keep_r      <= keep_nxt;
            trap_r      <= trap_nxt;
            inval_r     <= inval_nxt;
        end
    end

    assign o_dec_valid    = dec_valid_r;
    assign o_dec_class    = dec_class_r;
    assign o_len_min      = len_min_r;
    assign o_len_max      = len_max_r;
    assign o_pc_advance   = pc_adv_r;
    assign o_flags_keep   = keep_r;
    assign o_trap_req     = trap_r;
    assign o_icache_inval = inval_r;

    // ============================================================
    // processor status word and condition flags
    logic [PSW_W-1:0] psw_r, psw_nxt;
    logic [3:0]       old_nzvc;
    logic [3:0]       calc_nzvc;
    logic             arith_case;

    assign old_nzvc   = {psw_r[`SMD_PSW_N_BIT], psw_r[`SMD_PSW_Z_BIT],
                         psw_r[`SMD_PSW_V_BIT], psw_r[`SMD_PSW_C_BIT]};
    assign arith_case = (i_flag_case >= `SMD_FC_1) && (i_flag_case <= `SMD_FC_6);

    smd_flag_calc u_flag_calc (
        .i_case         (i_flag_case),
        .i_dst          (i_dst),
        .i_src          (i_src),
        .i_width        (i_width),
        .i_signed       (i_signed),
        .i_carry        (i_carry),
        .i_int_ovf      (i_int_ovf),
        .i_expanded     (i_expanded),
        .i_truncated    (i_truncated),
        .i_type_changed (i_type_changed),
        .i_abs_result   (i_abs_result),
        .i_old_nzvc     (old_nzvc),
        .o_nzvc         (calc_nzvc)
    );

    // next status word; coprocessor copy overrides a same-cycle flag update
    always_comb begin
        psw_nxt = psw_r;
        if (i_flag_valid) begin
            if (arith_case && i_psw_is_src) begin
                psw_nxt = psw_r;
            end else if (arith_case && i_psw_is_dst) begin
                psw_nxt[`SMD_PSW_FLAG_HI:`SMD_PSW_FLAG_LO] =
                    i_dst[`SMD_PSW_FLAG_HI:`SMD_PSW_FLAG_LO];
            end else if (i_flag_case == `SMD_FC_8 || i_flag_case == `SMD_FC_9) begin
                psw_nxt = i_new_psw;
            end else if (i_flag_case >= `SMD_FC_1 && i_flag_case <= `SMD_FC_7) begin
                psw_nxt[`SMD_PSW_N_BIT] = calc_nzvc[3];
                psw_nxt[`SMD_PSW_Z_BIT] = calc_nzvc[2];
                psw_nxt[`SMD_PSW_V_BIT] = calc_nzvc[1];
                psw_nxt[`SMD_PSW_C_BIT] = calc_nzvc[0];
            end
        end
        if (i_cop_accept) begin
            psw_nxt[`SMD_PSW_FLAG_HI:`SMD_PSW_FLAG_LO] =
                i_cop_word[`SMD_PSW_FLAG_HI:`SMD_PSW_FLAG_LO];
        end
    end

    // status word register
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            psw_r <= PSW_W'(`SMD_PSW_RESET);
        end else begin
            psw_r <= psw_nxt;
        end
    end

    assign o_psw    = psw_r;
    assign o_flag_n = psw_r[`SMD_PSW_N_BIT];
    assign o_flag_z = psw_r[`SMD_PSW_Z_BIT];
    assign o_flag_v = psw_r[`SMD_PSW_V_BIT];
    assign o_flag_c = psw_r[`SMD_PSW_C_BIT];

endmodule // smd_decode

// [shared/smd_defs.svh]
// smd_defs.svh: opcode values, flag positions, flag case codes and reset values
// for the stack/misc decoder and the condition-flag unit.
// assumes: included by bare name and protected by its own guard.
`ifndef SMD_DEFS_SVH
`define SMD_DEFS_SVH

// ============================================================
// opcodes of the stack and miscellaneous group
`define SMD_OP_PUSH_EFF_ADDR  8'hE0
`define SMD_OP_PUSH_WORD      8'hA0
`define SMD_OP_POP_WORD       8'h20
`define SMD_OP_IDLE_ONE       8'h70
`define SMD_OP_IDLE_TWO       8'h73
`define SMD_OP_IDLE_THREE     8'h72
`define SMD_OP_BREAKPOINT     8'h2E
`define SMD_OP_ICACHE_INVAL   8'h27
`define SMD_OP_EXTENSION      8'h14

// ============================================================
// instruction lengths in bytes
`define SMD_LEN_STACK_MIN     3'h2
`define SMD_LEN_STACK_MAX     3'h6
`define SMD_LEN_ONE           3'h1
`define SMD_LEN_TWO           3'h2
`define SMD_LEN_THREE         3'h3
`define SMD_LEN_NONE          3'h0

// ============================================================
// condition flag positions in the processor status word
`define SMD_PSW_C_BIT         18
`define SMD_PSW_V_BIT         19
`define SMD_PSW_Z_BIT         20
`define SMD_PSW_N_BIT         21
`define SMD_PSW_FLAG_LO       18
`define SMD_PSW_FLAG_HI       21

// ============================================================
// flag case codes
`define SMD_FC_NONE           4'h0
`define SMD_FC_1              4'h1
`define SMD_FC_2              4'h2
`define SMD_FC_3              4'h3
`define SMD_FC_4              4'h4
`define SMD_FC_5              4'h5
`define SMD_FC_6              4'h6
`define SMD_FC_7              4'h7
`define SMD_FC_8              4'h8
`define SMD_FC_9              4'h9
`define SMD_FC_10             4'hA

// ============================================================
// reset values
`define SMD_PSW_RESET         32'h0000_0000

`endif

// [shared/smd_pkg.sv]
// smd_pkg: types shared by the decoder and the flag unit.
// assumes: compiled before every module that imports it.
package smd_pkg;

    // ============================================================
    // decoded instruction class
    typedef enum logic [3:0] {
        SMD_CLS_NONE        = 4'b0000,
        SMD_CLS_PUSH_EFF    = 4'b0001,
        SMD_CLS_PUSH_WORD   = 4'b0010,
        SMD_CLS_POP_WORD    = 4'b0011,
        SMD_CLS_IDLE_ONE    = 4'b0100,
        SMD_CLS_IDLE_TWO    = 4'b0101,
        SMD_CLS_IDLE_THREE  = 4'b0110,
        SMD_CLS_BREAKPOINT  = 4'b0111,
        SMD_CLS_ICACHE_INV  = 4'b1000,
        SMD_CLS_EXTENSION   = 4'b1001
    } smd_class_e;

    // ============================================================
    // operand width of the destination or source
    typedef enum logic [1:0] {
        SMD_W_BYTE = 2'b00,
        SMD_W_HALF = 2'b01,
        SMD_W_WORD = 2'b10
    } smd_width_e;

endpackage

// [src/smd_flag_calc.sv]
// smd_flag_calc: combinational condition-flag computation for one flag case.
// assumes: all inputs come from logic on the same core clock.
`timescale 1ns/1ns
`include "smd_defs.svh"

module smd_flag_calc
    import smd_pkg::*;
(
    input  wire logic [3:0]  i_case,
    input  wire logic [31:0] i_dst,
    input  wire logic [31:0] i_src,
    input  wire smd_width_e  i_width,
    input  wire logic        i_signed,
    input  wire logic        i_carry,
    input  wire logic        i_int_ovf,
    input  wire logic        i_expanded,
    input  wire logic        i_truncated,
    input  wire logic        i_type_changed,
    input  wire logic [63:0] i_abs_result,
    input  wire logic [3:0]  i_old_nzvc,
    output logic      [3:0]  o_nzvc
);

    logic dst_msb;
    logic src_msb;
    logic dst_zero;
    logic src_zero;
    logic case4_exempt;

    // sign bit and zero test at the operand width
    always_comb begin
        unique case (i_width)
            SMD_W_BYTE: begin
                dst_msb  = i_dst[7];
                src_msb  = i_src[7];
                dst_zero = (i_dst[7:0] == 8'h00);
                src_zero = (i_src[7:0] == 8'h00);
            end
            SMD_W_HALF: begin
                dst_msb  = i_dst[15];
                src_msb  = i_src[15];
                dst_zero = (i_dst[15:0] == 16'h0000);
                src_zero = (i_src[15:0] == 16'h0000);
            end
            default: begin
                dst_msb  = i_dst[31];
                src_msb  = i_src[31];
                dst_zero = (i_dst == 32'h0000_0000);
                src_zero = (i_src == 32'h0000_0000);
            end
        endcase
    end

    // signed word whose magnitude has bit 31 set and fits in 32 bits leaves overflow clear
    assign case4_exempt = i_signed && (i_width == SMD_W_WORD) && i_abs_result[31]
                          && (i_abs_result[63:32] == 32'h0000_0000);

    // flags ordered n, z, v, c
    always_comb begin
        o_nzvc = i_old_nzvc;
        unique case (i_case)
            `SMD_FC_1: o_nzvc = {dst_msb, dst_zero, i_expanded & i_truncated, 1'b0};
            `SMD_FC_2: o_nzvc = {i_signed & dst_msb, dst_zero, i_int_ovf, i_carry};
            `SMD_FC_3: o_nzvc = {i_signed & dst_msb, dst_zero, i_int_ovf, 1'b0};
            `SMD_FC_4: o_nzvc = {i_signed & dst_msb, dst_zero, i_int_ovf & ~case4_exempt, 1'b0};
            `SMD_FC_5: o_nzvc = {i_signed & dst_msb, dst_zero,
                                 i_expanded & i_type_changed & i_int_ovf, 1'b0};
            `SMD_FC_6: o_nzvc = {i_signed ? src_msb : i_old_nzvc[3], src_zero, 1'b0, 1'b0};
            `SMD_FC_7: o_nzvc = {i_dst[31], i_dst == 32'h0000_0000, 1'b0, 1'b0};
            default:   o_nzvc = i_old_nzvc;
        endcase
    end

endmodule // smd_flag_calc

// [testbench/smd_decode_asserts.sv]
// smd_decode_asserts.sv: port-level checks for the stack/misc decoder and flag unit.
// assumes: bound to every smd_decode instance, single core clock, async high reset.
`timescale 1ns/1ns

module smd_decode_asserts
    import smd_pkg::*;
#(
    parameter int PSW_W = 32
) (
    input wire logic             i_core_clk,
    input wire logic             i_rst,
    input wire logic             i_op_valid,
    input wire logic [7:0]       i_opcode,
    input wire logic             o_dec_valid,
    input wire smd_class_e       o_dec_class,
    input wire logic [2:0]       o_len_min,
    input wire logic [2:0]       o_len_max,
    input wire logic [2:0]       o_pc_advance,
    input wire logic             o_flags_keep,
    input wire logic             o_trap_req,
    input wire logic             o_icache_inval,
    input wire logic             i_flag_valid,
    input wire logic [3:0]       i_flag_case,
    input wire logic [31:0]      i_dst,
    input wire smd_width_e       i_width,
    input wire logic             i_signed,
    input wire logic [63:0]      i_abs_result,
    input wire logic             i_psw_is_src,
    input wire logic             i_psw_is_dst,
    input wire logic [PSW_W-1:0] i_new_psw,
    input wire logic             i_cop_accept,
    input wire logic [31:0]      i_cop_word,
    input wire logic [PSW_W-1:0] o_psw,
    input wire logic             o_flag_n,
    input wire logic             o_flag_z,
    input wire logic             o_flag_v,
    input wire logic             o_flag_c
);
    // ============================================================
    // common clocking and request shapes
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    wire upd  = i_flag_valid && !i_cop_accept;
    wire fc16 = upd && i_flag_case >= 4'h1 && i_flag_case <= 4'h6;
    sequence s_op(logic [7:0] c);
        i_op_valid && i_opcode == c;
    endsequence
    property p_dec(logic [7:0] c, smd_class_e k, logic [2:0] mn, logic [2:0] mx, logic [2:0] ad, logic kp);
        s_op(c) |=> o_dec_valid && o_dec_class == k && o_len_min == mn && o_len_max == mx
                    && o_pc_advance == ad && o_flags_keep == kp;
    endproperty

    // ============================================================
    // decode answers
    chk_push_addr_dec: assert property (p_dec(8'hE0, SMD_CLS_PUSH_EFF, 3'h2, 3'h6, 3'h0, 1'b0))
        else $error("push address decode wrong");
    chk_idle_one_dec: assert property (p_dec(8'h70, SMD_CLS_IDLE_ONE, 3'h1, 3'h1, 3'h1, 1'b1))
        else $error("one byte idle decode wrong");
    chk_idle_two_dec: assert property (p_dec(8'h73, SMD_CLS_IDLE_TWO, 3'h2, 3'h2, 3'h2, 1'b1))
        else $error("two byte idle decode wrong");
    chk_idle_three_dec: assert property (p_dec(8'h72, SMD_CLS_IDLE_THREE, 3'h3, 3'h3, 3'h3, 1'b1))
        else $error("three byte idle decode wrong");
    chk_trap_pulse: assert property (s_op(8'h2E) |=> o_trap_req && o_flags_keep && !o_icache_inval)
        else $error("breakpoint trap request missing");
    chk_decode_no_flags: assert property (i_op_valid && !i_flag_valid && !i_cop_accept |=> $stable(o_psw))
        else $error("decode changed status word");

    // ============================================================
    // flag updates
    chk_case4_exempt: assert property (fc16 && !i_psw_is_src && !i_psw_is_dst && i_flag_case == 4'h4 && i_signed
        && i_width == SMD_W_WORD && i_abs_result[31] && i_abs_result[63:32] == 32'h0 |=> !o_flag_v && !o_flag_c)
        else $error("case four overflow exemption broken");
    chk_case7_word: assert property (upd && i_flag_case == 4'h7 |=> o_flag_n == ($past(i_dst) >= 32'h8000_0000)
        && o_flag_z == ($past(i_dst) == 32'h0) && !o_flag_v && !o_flag_c)
        else $error("case seven flags wrong");
    chk_psw_load: assert property (upd && (i_flag_case == 4'h8 || i_flag_case == 4'h9) |=> o_psw == $past(i_new_psw))
        else $error("status word load wrong");
    chk_cop_copy: assert property (i_cop_accept |=> o_psw[21:18] == 4'($past(i_cop_word) >> 18))
        else $error("coprocessor flag copy wrong");
    chk_psw_src_hold: assert property (fc16 && i_psw_is_src |=> $stable(o_psw))
        else $error("status word source changed flags");
    chk_psw_dst_take: assert property (fc16 && i_psw_is_dst && !i_psw_is_src |=> o_psw[21:18] == 4'($past(i_dst) >> 18))
        else $error("status word destination flags wrong");
endmodule // smd_decode_asserts

bind smd_decode smd_decode_asserts #(.PSW_W(PSW_W)) u_chk (.*);

// [testbench/tb_stack_misc_decode_and_cond_flags.sv]
// tb_stack_misc_decode_and_cond_flags: directed test of opcode decode and flag cases.
// assumes: smd_pkg compiled first; checker bound through its own file.
`timescale 1ns/1ns

module tb_stack_misc_decode_and_cond_flags
    import smd_pkg::*;
;
    // ============================================================
    // stimulus and observed signals
    logic        i_core_clk, i_rst, i_op_valid, i_flag_valid, i_signed, i_carry, i_int_ovf;
    logic        i_expanded, i_truncated, i_type_changed, i_psw_is_src, i_psw_is_dst, i_cop_accept;
    logic [7:0]  i_opcode;
    logic [3:0]  i_flag_case;
    logic [31:0] i_dst, i_src, i_new_psw, i_cop_word, o_psw;
    logic [63:0] i_abs_result;
    smd_width_e  i_width;
    smd_class_e  o_dec_class;
    logic        o_dec_valid, o_flags_keep, o_trap_req, o_icache_inval;
    logic        o_flag_n, o_flag_z, o_flag_v, o_flag_c;
    logic [2:0]  o_len_min, o_len_max, o_pc_advance;
    int          miscompares, n_compared;

    smd_decode u_dut (.*);

    // 8 ns core clock
    initial begin
        i_core_clk = 1'b0;
        forever #4 i_core_clk = ~i_core_clk;
    end

    // ============================================================
    // access tasks
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        n_compared++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // one opcode, answer looked at one cycle later
    task automatic dec(input logic [7:0] c, input logic [16:0] e);
        @(posedge i_core_clk);
        i_op_valid <= 1'b1;
        i_opcode <= c;
        @(posedge i_core_clk);
        i_op_valid <= 1'b0;
        #1;
        chk("decode", e, {o_dec_valid, o_dec_class, o_len_min, o_len_max, o_pc_advance,
                          o_flags_keep, o_trap_req, o_icache_inval});
    endtask

    // cn: psw_is_src, psw_is_dst, signed, carry, int_ovf, expanded, truncated, type_changed
    task automatic fl(input logic [3:0] fc, input logic [7:0] cn, input logic [31:0] d,
                      input logic [31:0] s, input logic [63:0] ab, input logic [3:0] e);
        @(posedge i_core_clk);
        i_flag_valid <= 1'b1;
        i_flag_case <= fc;
        {i_psw_is_src, i_psw_is_dst, i_signed, i_carry, i_int_ovf, i_expanded, i_truncated, i_type_changed} <= cn;
        i_width <= (fc == 4'h1) ? SMD_W_BYTE : (fc == 4'h3) ? SMD_W_HALF : SMD_W_WORD;
        i_dst <= d;
        i_new_psw <= d;
        i_src <= s;
        i_abs_result <= ab;
        @(posedge i_core_clk);
        i_flag_valid <= 1'b0;
        #1;
        chk("flags nzvc", e, {o_flag_n, o_flag_z, o_flag_v, o_flag_c});
    endtask

    // ============================================================
    // watchdog against a hung run
    initial begin
        #100000;
        miscompares++;
        finish_test();
    end

    // ============================================================
    // main sequence
    initial begin
        i_rst = 1'b1;
        {i_op_valid, i_opcode, i_flag_valid, i_flag_case, i_dst, i_src, i_signed, i_carry, i_int_ovf,
         i_expanded, i_truncated, i_type_changed, i_abs_result, i_psw_is_src, i_psw_is_dst,
         i_new_psw, i_cop_accept, i_cop_word} = '0;
        i_width = SMD_W_BYTE;
        repeat (8) @(posedge i_core_clk);
        i_rst <= 1'b0;
        #1;
        chk("psw reset", 32'h0, o_psw);
        // every opcode of the group plus one outside it
        dec(8'hE0, {1'b1, SMD_CLS_PUSH_EFF, 3'h2, 3'h6, 3'h0, 3'h0});
        dec(8'hA0, {1'b1, SMD_CLS_PUSH_WORD, 3'h2, 3'h6, 3'h0, 3'h0});
        dec(8'h20, {1'b1, SMD_CLS_POP_WORD, 3'h2, 3'h6, 3'h0, 3'h0});
        dec(8'h70, {1'b1, SMD_CLS_IDLE_ONE, 3'h1, 3'h1, 3'h1, 3'h4});
        dec(8'h73, {1'b1, SMD_CLS_IDLE_TWO, 3'h2, 3'h2, 3'h2, 3'h4});
        dec(8'h72, {1'b1, SMD_CLS_IDLE_THREE, 3'h3, 3'h3, 3'h3, 3'h4});
        dec(8'h2E, {1'b1, SMD_CLS_BREAKPOINT, 3'h1, 3'h1, 3'h0, 3'h6});
        dec(8'h27, {1'b1, SMD_CLS_ICACHE_INV, 3'h1, 3'h1, 3'h0, 3'h5});
        dec(8'h14, {1'b1, SMD_CLS_EXTENSION, 3'h1, 3'h2, 3'h0, 3'h4});
        dec(8'h10, 17'h0_0000);
        // back-to-back trap and invalidate, pulses one cycle each
        @(posedge i_core_clk);
        i_op_valid <= 1'b1;
        i_opcode <= 8'h2E;
        @(posedge i_core_clk);
        i_opcode <= 8'h27;
        #1;
        chk("trap inval", 2'h2, {o_trap_req, o_icache_inval});
        @(posedge i_core_clk);
        i_op_valid <= 1'b0;
        #1;
        chk("trap inval", 2'h1, {o_trap_req, o_icache_inval});
        chk("psw kept", 32'h0, o_psw);
        // flag cases, carry and overflow inputs raised where they must be ignored
        fl(4'h1, 8'h06, 32'h0000_0080, 32'h0, 64'h0, 4'hA);
        fl(4'h2, 8'h38, 32'h0, 32'h0, 64'h0, 4'h7);
        fl(4'h3, 8'h38, 32'hFFFF_FFF0, 32'h0, 64'h0, 4'hA);
        // half width: sign from bit 15, zero test on the low 16 bits only
        fl(4'h3, 8'h20, 32'h0001_8000, 32'h0, 64'h0, 4'h8);
        fl(4'h3, 8'h20, 32'h0001_0000, 32'h0, 64'h0, 4'h4);
        fl(4'h4, 8'h28, 32'h8000_0000, 32'h0, 64'h0000_0000_8000_0000, 4'h8);
        fl(4'h4, 8'h28, 32'h8000_0000, 32'h0, 64'h0000_0001_8000_0000, 4'hA);
        fl(4'h5, 8'h2D, 32'h1, 32'h0, 64'h0, 4'h2);
        fl(4'h5, 8'h2C, 32'h1, 32'h0, 64'h0, 4'h0);
        fl(4'h6, 8'h38, 32'h0, 32'h8000_0000, 64'h0, 4'h8);
        fl(4'h6, 8'h00, 32'h1, 32'h0, 64'h0, 4'hC);
        fl(4'h7, 8'h38, 32'h0, 32'h0, 64'h0, 4'h4);
        fl(4'h7, 8'h00, 32'h8000_0001, 32'h0, 64'h0, 4'h8);
        fl(4'h8, 8'h00, 32'h0028_0000, 32'h0, 64'h0, 4'hA);
        chk("psw", 32'h0028_0000, o_psw);
        fl(4'h3, 8'hB8, 32'h0, 32'h0, 64'h0, 4'hA);
        fl(4'h2, 8'h78, 32'h0030_0000, 32'h0, 64'h0, 4'hC);
        fl(4'hA, 8'h00, 32'h0, 32'h0, 64'h0, 4'hC);
        fl(4'h0, 8'h38, 32'h0, 32'h0, 64'h0, 4'hC);
        fl(4'hB, 8'h38, 32'h0, 32'h0, 64'h0, 4'hC);
        fl(4'h9, 8'h00, 32'h0014_0000, 32'h0, 64'h0, 4'h5);
        // accepted coprocessor word, only bits 18-21 may land
        @(posedge i_core_clk);
        i_cop_accept <= 1'b1;
        i_cop_word <= 32'hFFE7_FFFF;
        @(posedge i_core_clk);
        i_cop_accept <= 1'b0;
        #1;
        chk("psw", 32'h0024_0000, o_psw);
        // reset in mid-run clears the status word, decode resumes right after
        @(posedge i_core_clk);
        i_rst <= 1'b1;
        @(posedge i_core_clk);
        i_rst <= 1'b0;
        #1;
        chk("psw mid reset", 32'h0, o_psw);
        chk("flags mid reset", 4'h0, {o_flag_n, o_flag_z, o_flag_v, o_flag_c});
        dec(8'h73, {1'b1, SMD_CLS_IDLE_TWO, 3'h2, 3'h2, 3'h2, 3'h4});
        finish_test();
    end
endmodule // tb_stack_misc_decode_and_cond_flags
